// >>> tsc_consts.svh
// Purpose: offsets, field positions, reset values and codes of the trigger sequencer control
// Assumes: 32-bit classic Wishbone, byte addresses, 16-bit registers in the low half
// Notes: definitions only
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

`define TSC_ADR_CST 8'h00
`define TSC_ADR_CON 8'h04
`define TSC_ADR_BTE 8'h08
`define TSC_ADR_T0LIM 8'h0C
`define TSC_ADR_T1LIM 8'h10
`define TSC_ADR_SDLIM 8'h14

`define TSC_RST_REG 16'h0000
`define TSC_CST_WMASK 16'hB7C3
`define TSC_CON_WMASK 16'hFFF7

`define TSC_CST_EN 15
`define TSC_CST_SIDL 13
`define TSC_CST_TOGL 12
`define TSC_CST_SWT 10
`define TSC_CST_SSEN 9
`define TSC_CST_VIS 8
`define TSC_CST_STRT 7
`define TSC_CST_WDTO 6
`define TSC_CST_ITM_LVL 1
`define TSC_CST_ITM_SKIP 0

`define TSC_CMD_CTRL 4'h0
`define TSC_CMD_WHI 4'h4
`define TSC_CMD_WLO 4'h5
`define TSC_CMD_TRIG 3'h4
`define TSC_OPT_BCAST 4'hF
`define TSC_OPT_T0 4'h8
`define TSC_OPT_T1 4'h9
`define TSC_OPT_SWT 4'hA

`define TSC_CLK_SYS 3'h0
`define TSC_CLK_LAST 3'h5
`define TSC_WDT_BASE 10'h004

`endif

// >>> tsc_pkg.sv
// Purpose: types of the trigger sequencer control
// Assumes: nothing
// Notes: the whole module state is one packed struct
package tsc_pkg;

  typedef enum logic [2:0] {
    TSC_IDLE,
    TSC_WAIT,
    TSC_TIMER,
    TSC_SWT,
    TSC_DELAY
  } tsc_state_type;

  typedef struct packed {
    tsc_state_type st;
    logic [15:0] cst;
    logic [15:0] con;
    logic [15:0] bte;
    logic [15:0] t0lim;
    logic [15:0] t1lim;
    logic [15:0] sdlim;
    logic [15:0] t0cnt;
    logic [15:0] t1cnt;
    logic [15:0] sdcnt;
    logic [9:0] wdt;
    logic [4:0] div;
    logic [4:0] pw;
    logic [31:0] tout;
    logic [31:0] pmask;
    logic [3:0] adc;
    logic [3:0] ics;
    logic [3:0] occ;
    logic [3:0] ocs;
    logic [15:0] tsync1;
    logic [15:0] tsync2;
    logic [4:0] csync1;
    logic [4:0] csync2;
    logic [4:0] csync3;
    logic [3:0] opt;
    logic skip;
    logic rise;
    logic prev;
    logic ready;
    logic ack;
    logic [15:0] rdata;
    logic wdt_evt;
    logic step_evt;
  } tsc_state_s_type;

endpackage

// >>> tsc_sequencer_control.sv
// Purpose: control, status and step execution of the trigger sequencer
// Assumes: step bytes arrive from a queue on the same clock; trig_in_i and clk_src_i are asynchronous
// Notes: Wishbone slave answers every access one cycle after the strobe
// Notes on behaviour
// - sequencer works only while the module enable bit is one.
// - with stop-in-idle set, sequencer halts while the device idles.
// - toggle mode set: each trigger-output command inverts the selected output.
// - toggle mode clear: each trigger-output command emits one pulse.
// - writing one to software trigger triggers; writing zero does nothing.
// - single-step enable bit places the sequencer in single-step mode.
// - visibility set: limit reads return live counter or timer values.
// - start bit set runs queued commands continuously; clear stops them.
// - hardware sets watchdog time-out flag on expiry; software clears it.
// - input trigger mode picks level or edge detect for wait commands.
// - modes 11 and 01 skip the step delay on wait exit.
// - broadcast pulses each enabled compare clock line once.
// - broadcast sends trigger or sync to each enabled unit.
// - broadcast enables are used only by control option 1111.
// - enables and limits are read-only while enabled and started.
// - timer-0 limit acts only in the timer-0 step command.
// - step delay equals step-delay limit plus one sequencer clock.
// - command byte: code in upper nibble, option in lower nibble; trigger-output commands use bits 7:5 as code and 4:0 as output.
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "tsc_consts.svh"

module tsc_sequencer_control
  import tsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic idle_mode_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  output logic cmd_ready_o,
  input wire logic [15:0] trig_in_i,
  input wire logic [4:0] clk_src_i,
  output logic [31:0] trigger_output_o,
  output logic [3:0] converter_sample_trigger_o,
  output logic [3:0] capture_sync_o,
  output logic [3:0] compare_clock_o,
  output logic [3:0] compare_sync_o,
  output logic watchdog_timeout_o,
  output logic step_done_o
);

  tsc_state_s_type s_ff;
  tsc_state_s_type s;
  logic [2:0] csel;
  logic raw_tick;
  logic tick;
  logic run;
  logic locked;
  logic bus_req;
  logic wr;
  logic take;
  logic expire;
  logic finish;
  logic hit;
  logic cur;
  logic [15:0] merged;

  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wd,
                                             input logic [1:0] sel, input logic [15:0] mask);
    lane_merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]} & mask;
  endfunction

  function automatic logic [9:0] wdt_limit(input logic [2:0] sel);
    wdt_limit = `TSC_WDT_BASE << sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sequencer clock: source select and divider
  // source and divider
  assign csel = s_ff.con[15:13];
  assign raw_tick = (csel == `TSC_CLK_SYS) ? 1'b1 :
                    (csel <= `TSC_CLK_LAST) ? (s_ff.csync2[csel - 3'h1] & ~s_ff.csync3[csel - 3'h1]) : 1'b0;
  assign tick = raw_tick && (s_ff.div == s_ff.con[12:8]);

  assign run = s_ff.cst[`TSC_CST_EN] && s_ff.cst[`TSC_CST_STRT] && !(s_ff.cst[`TSC_CST_SIDL] && idle_mode_i);
  assign locked = s_ff.cst[`TSC_CST_EN] && s_ff.cst[`TSC_CST_STRT];
  assign bus_req = wb_cyc_i && wb_stb_i && !s_ff.ack;
  assign wr = bus_req && wb_we_i;
  assign take = cmd_valid_i && s_ff.ready;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s = s_ff;
    merged = `TSC_RST_REG;
    expire = 1'b0;
    finish = 1'b0;
    hit = 1'b0;
    cur = s_ff.tsync2[s_ff.opt];
    s.ack = 1'b0;
    s.wdt_evt = 1'b0;
    s.step_evt = 1'b0;
    s.adc = 4'h0;
    s.ics = 4'h0;
    s.occ = 4'h0;
    s.ocs = 4'h0;
    // inputs cross in through two flops; the third only feeds the edge detector
    s.tsync1 = trig_in_i;
    s.tsync2 = s_ff.tsync1;
    s.csync1 = clk_src_i;
    s.csync2 = s_ff.csync1;
    s.csync3 = s_ff.csync2;
    if (raw_tick) begin
      s.div = tick ? 5'h00 : s_ff.div + 5'h01;
    end
    if (tick && s_ff.pw != 5'h00) begin
      s.pw = s_ff.pw - 5'h01;
      if (s_ff.pw == 5'h01) begin
        s.tout = s_ff.tout & ~s_ff.pmask;
        s.pmask = 32'h0000_0000;
      end
    end
    case (s_ff.st)
      TSC_IDLE: begin
        if (take) begin
          s.opt = cmd_byte_i[3:0];
          s.sdcnt = 16'h0000;
          s.wdt = 10'h000;
          s.skip = 1'b0;
          s.st = TSC_DELAY;
          if (cmd_byte_i[7:5] == `TSC_CMD_TRIG) begin
            if (s_ff.cst[`TSC_CST_TOGL]) begin
              s.tout[cmd_byte_i[4:0]] = ~s_ff.tout[cmd_byte_i[4:0]];
            end else begin
              s.tout[cmd_byte_i[4:0]] = 1'b1;
              s.pmask[cmd_byte_i[4:0]] = 1'b1;
              s.pw = {1'b0, s_ff.con[7:4]} + 5'h01;
            end
          end else if (cmd_byte_i[7:4] == `TSC_CMD_WHI || cmd_byte_i[7:4] == `TSC_CMD_WLO) begin
            s.st = TSC_WAIT;
            s.rise = (cmd_byte_i[7:4] == `TSC_CMD_WHI);
            s.prev = s_ff.tsync2[cmd_byte_i[3:0]];
            s.skip = s_ff.cst[`TSC_CST_ITM_SKIP];
          end else if (cmd_byte_i[7:4] == `TSC_CMD_CTRL) begin
            if (cmd_byte_i[3:0] == `TSC_OPT_BCAST) begin
              s.adc = s_ff.bte[15:12];
              s.ics = s_ff.bte[11:8];
              s.occ = s_ff.bte[7:4];
              s.ocs = s_ff.bte[3:0];
            end else if (cmd_byte_i[3:0] == `TSC_OPT_T0) begin
              s.t0cnt = 16'h0000;
              s.st = TSC_TIMER;
            end else if (cmd_byte_i[3:0] == `TSC_OPT_T1) begin
              s.t1cnt = 16'h0000;
              s.st = TSC_TIMER;
            end else if (cmd_byte_i[3:0] == `TSC_OPT_SWT) begin
              s.st = TSC_SWT;
            end
          end
        end
      end
      TSC_WAIT: begin
        s.prev = cur;
        if (s_ff.cst[`TSC_CST_ITM_LVL]) begin
          hit = s_ff.rise ? cur : !cur;
        end else begin
          hit = s_ff.rise ? (cur && !s_ff.prev) : (!cur && s_ff.prev);
        end
        if (hit) begin
          if (s_ff.skip) begin
            finish = 1'b1;
          end else begin
            s.st = TSC_DELAY;
          end
        end else if (tick && s_ff.con[2:0] != 3'h0) begin
          if (s_ff.wdt == wdt_limit(s_ff.con[2:0]) - 10'h001) begin
            expire = 1'b1;
            finish = 1'b1;
          end else begin
            s.wdt = s_ff.wdt + 10'h001;
          end
        end
      end
      TSC_SWT: begin
        if (s_ff.cst[`TSC_CST_SWT]) begin
          s.cst[`TSC_CST_SWT] = 1'b0;
          s.st = TSC_DELAY;
        end
      end
      TSC_TIMER: begin
        if (tick) begin
          if (!s_ff.opt[0]) begin
            if (s_ff.t0cnt == s_ff.t0lim) begin
              s.st = TSC_DELAY;
            end else begin
              s.t0cnt = s_ff.t0cnt + 16'h0001;
            end
          end else if (s_ff.t1cnt == s_ff.t1lim) begin
            s.st = TSC_DELAY;
          end else begin
            s.t1cnt = s_ff.t1cnt + 16'h0001;
          end
        end
      end
      TSC_DELAY: begin
        if (tick) begin
          if (s_ff.sdcnt == s_ff.sdlim) begin
            finish = 1'b1;
          end else begin
            s.sdcnt = s_ff.sdcnt + 16'h0001;
          end
        end
      end
      default: begin
        s.st = TSC_IDLE;
      end
    endcase
    if (finish) begin
      s.st = TSC_IDLE;
      s.step_evt = 1'b1;
      // single step halts after each step
      if (s_ff.cst[`TSC_CST_SSEN]) begin
        s.cst[`TSC_CST_STRT] = 1'b0;
      end
    end
    if (!run) begin
      s.st = TSC_IDLE;
    end
    if (!s_ff.cst[`TSC_CST_EN]) begin
      s.tout = 32'h0000_0000;
      s.pmask = 32'h0000_0000;
      s.pw = 5'h00;
    end
    //////////////////////////////////////////////////////////////////////////
    // register bus
    if (bus_req) begin
      s.ack = 1'b1;
      s.rdata = `TSC_RST_REG;
      if (wb_adr_i == `TSC_ADR_CST) begin
        s.rdata = s_ff.cst;
      end else if (wb_adr_i == `TSC_ADR_CON) begin
        s.rdata = s_ff.con;
      end else if (wb_adr_i == `TSC_ADR_BTE) begin
        s.rdata = s_ff.bte;
      end else if (wb_adr_i == `TSC_ADR_T0LIM) begin
        s.rdata = s_ff.cst[`TSC_CST_VIS] ? s_ff.t0cnt : s_ff.t0lim;
      end else if (wb_adr_i == `TSC_ADR_T1LIM) begin
        s.rdata = s_ff.cst[`TSC_CST_VIS] ? s_ff.t1cnt : s_ff.t1lim;
      end else if (wb_adr_i == `TSC_ADR_SDLIM) begin
        s.rdata = s_ff.cst[`TSC_CST_VIS] ? s_ff.sdcnt : s_ff.sdlim;
      end
    end
    if (wr) begin
      if (wb_adr_i == `TSC_ADR_CST) begin
        merged = lane_merge(s.cst, wb_dat_i[15:0], wb_sel_i[1:0], `TSC_CST_WMASK);
        merged[`TSC_CST_SWT] = s.cst[`TSC_CST_SWT] | merged[`TSC_CST_SWT];
        merged[`TSC_CST_WDTO] = s_ff.cst[`TSC_CST_WDTO] & merged[`TSC_CST_WDTO];
        s.cst = merged;
      end else if (wb_adr_i == `TSC_ADR_CON) begin
        s.con = lane_merge(s_ff.con, wb_dat_i[15:0], wb_sel_i[1:0], `TSC_CON_WMASK);
      end else if (!locked) begin
        if (wb_adr_i == `TSC_ADR_BTE) begin
          s.bte = lane_merge(s_ff.bte, wb_dat_i[15:0], wb_sel_i[1:0], 16'hFFFF);
        end else if (wb_adr_i == `TSC_ADR_T0LIM) begin
          s.t0lim = lane_merge(s_ff.t0lim, wb_dat_i[15:0], wb_sel_i[1:0], 16'hFFFF);
        end else if (wb_adr_i == `TSC_ADR_T1LIM) begin
          s.t1lim = lane_merge(s_ff.t1lim, wb_dat_i[15:0], wb_sel_i[1:0], 16'hFFFF);
        end else if (wb_adr_i == `TSC_ADR_SDLIM) begin
          s.sdlim = lane_merge(s_ff.sdlim, wb_dat_i[15:0], wb_sel_i[1:0], 16'hFFFF);
        end
      end
    end
    if (expire) begin
      s.cst[`TSC_CST_WDTO] = 1'b1;
      s.wdt_evt = 1'b1;
    end
    // ready follows the next register values so it never lags a stop
    s.ready = (s.st == TSC_IDLE) && !take && s.cst[`TSC_CST_EN] && s.cst[`TSC_CST_STRT] &&
              !(s.cst[`TSC_CST_SIDL] && idle_mode_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= s;
    end
  end

  assign wb_dat_o = {16'h0000, s_ff.rdata};
  assign wb_ack_o = s_ff.ack;
  assign cmd_ready_o = s_ff.ready;
  assign trigger_output_o = s_ff.tout;
  assign converter_sample_trigger_o = s_ff.adc;
  assign capture_sync_o = s_ff.ics;
  assign compare_clock_o = s_ff.occ;
  assign compare_sync_o = s_ff.ocs;
  assign watchdog_timeout_o = s_ff.wdt_evt;
  assign step_done_o = s_ff.step_evt;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_disabled_idle: assert property (!s_ff.cst[`TSC_CST_EN] |-> !cmd_ready_o)
    else $error("ready while disabled");
  a_idle_halts: assert property (cmd_ready_o && s_ff.cst[`TSC_CST_SIDL] && idle_mode_i && !wb_stb_i
                                 |=> !cmd_ready_o)
    else $error("ready in idle with stop-in-idle");
  a_toggle_out: assert property (take && cmd_byte_i == 8'h81 && s_ff.cst[`TSC_CST_TOGL]
                                 |=> trigger_output_o[1] != $past(trigger_output_o[1]))
    else $error("toggle did not invert output");
  a_pulse_one: assert property (take && cmd_byte_i == 8'h80 && !s_ff.cst[`TSC_CST_TOGL] &&
                                s_ff.con[15:4] == 12'h000 |=> trigger_output_o[0] ##1 !trigger_output_o[0])
    else $error("one-clock pulse wrong");
  a_swt_zero: assert property (!s_ff.cst[`TSC_CST_SWT] && !(wr && wb_adr_i == `TSC_ADR_CST && wb_sel_i[1] &&
                               wb_dat_i[`TSC_CST_SWT]) |=> !s_ff.cst[`TSC_CST_SWT])
    else $error("software trigger set without a one");
  a_vis_read: assert property (bus_req && !wb_we_i && wb_adr_i == `TSC_ADR_T0LIM && s_ff.cst[`TSC_CST_VIS]
                               |=> wb_ack_o && wb_dat_o[15:0] == $past(s_ff.t0cnt))
    else $error("visible read not live value");
  a_stop_idle: assert property (!s_ff.cst[`TSC_CST_STRT] |-> !cmd_ready_o && s_ff.st == TSC_IDLE)
    else $error("running while not started");
  a_wdt_flag: assert property (expire |=> s_ff.cst[`TSC_CST_WDTO] && watchdog_timeout_o && step_done_o)
    else $error("watchdog expiry not flagged");
  a_bcast_out: assert property (take && cmd_byte_i == 8'h0F |=> compare_clock_o == $past(s_ff.bte[7:4]) &&
                                compare_sync_o == $past(s_ff.bte[3:0]) &&
                                converter_sample_trigger_o == $past(s_ff.bte[15:12]))
    else $error("broadcast outputs differ from enables");
  a_bcast_only: assert property (!(take && cmd_byte_i == 8'h0F)
                                 |=> compare_clock_o == 4'h0 && capture_sync_o == 4'h0)
    else $error("broadcast outputs without broadcast");
  a_lock_bte: assert property (wr && locked && wb_adr_i == `TSC_ADR_BTE |=> $stable(s_ff.bte))
    else $error("enables written while running");
  a_skip_delay: assert property (s_ff.st == TSC_WAIT && hit && s_ff.skip |=> step_done_o && s_ff.st == TSC_IDLE)
    else $error("skip mode still delayed");

  c_trig_pulse: cover property (take && cmd_byte_i[7:5] == `TSC_CMD_TRIG ##[1:40] step_done_o);
  c_wdt_expire: cover property (expire);
  c_bcast: cover property (take && cmd_byte_i == 8'h0F);
  c_wait_exit: cover property (s_ff.st == TSC_WAIT && hit);

endmodule

// >>> tsc_unit_model.sv
// Purpose: far-side units of the trigger sequencer: trigger sources and pulse receivers
// Assumes: same clock as the sequencer; clr_i starts a fresh measurement
// Notes: trigger inputs follow level_i after lag_i plus one cycles, so both prompt and slow sources occur
`timescale 1ns/10ps

module tsc_unit_model (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [15:0] level_i,
  input wire logic [3:0] lag_i,
  input wire logic [31:0] trigger_output_i,
  input wire logic [15:0] bcast_i,
  output logic [15:0] trig_in_o,
  output logic [15:0] bcast_seen_o,
  output logic [7:0] bcast_cnt_o,
  output logic [7:0] pulse_len_o
);
  logic [3:0] wait_ff;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      trig_in_o <= 16'h0000;
      wait_ff <= 4'h0;
      bcast_seen_o <= 16'h0000;
      bcast_cnt_o <= 8'h00;
      pulse_len_o <= 8'h00;
    end else begin
      // slow source: new level shows only after the lag
      if (level_i != trig_in_o) begin
        wait_ff <= wait_ff + 4'h1;
        if (wait_ff >= lag_i) begin
          trig_in_o <= level_i;
          wait_ff <= 4'h0;
        end
      end
      bcast_seen_o <= bcast_seen_o | bcast_i;
      if (bcast_i != 16'h0000) begin
        bcast_cnt_o <= bcast_cnt_o + 8'h01;
      end
      if (trigger_output_i[0]) begin
        pulse_len_o <= pulse_len_o + 8'h01;
      end
    end
  end
endmodule

// >>> tsc_sequencer_control_bench.sv
// Purpose: self-checking bench of the trigger sequencer control
// Assumes: system clock as sequencer clock, divide by one
// Notes: step timing counted in clock edges after the take edge
`timescale 1ns/10ps
`include "tsc_consts.svh"

module tsc_sequencer_control_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0, cvalid = 1'b0, clr = 1'b1, wd_seen;
  logic [7:0] adr = 8'h00, cbyte = 8'h00, bcnt, plen;
  logic [31:0] wdat = 32'h0000_0000, wb_dat_o, trigger_output_o;
  logic [3:0] sel = 4'h0, lag = 4'h0, conv, cap, occ, ocs;
  logic [4:0] csrc = 5'h00;
  logic [15:0] lvl = 16'h0000, q, bte, w, e, trig_in, seen;
  logic wb_ack_o, cmd_ready_o, wdo, done;
  int n_errors = 0, n_tests = 0, cycles = 0, c, d;
  int pws[3] = '{0, 3, 14};

  always #5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    csrc <= 5'($urandom);
  end

  tsc_sequencer_control u_tsc_sequencer_control (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .idle_mode_i(idle), .cmd_valid_i(cvalid), .cmd_byte_i(cbyte),
    .cmd_ready_o(cmd_ready_o), .trig_in_i(trig_in), .clk_src_i(csrc), .trigger_output_o(trigger_output_o),
    .converter_sample_trigger_o(conv), .capture_sync_o(cap), .compare_clock_o(occ), .compare_sync_o(ocs),
    .watchdog_timeout_o(wdo), .step_done_o(done));

  tsc_unit_model u_tsc_unit_model (.clk_i(clk_i), .clr_i(clr), .level_i(lvl), .lag_i(lag),
    .trigger_output_i(trigger_output_o), .bcast_i({conv, cap, occ, ocs}), .trig_in_o(trig_in),
    .bcast_seen_o(seen), .bcast_cnt_o(bcnt), .pulse_len_o(plen));

  ////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done;
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] x, input string nm);
    n_tests++;
    if (s !== x) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask

  // step length: ticks spent before the delay, delay limit plus one, then the done edge
  function automatic int exp_time(input int ticks, input int delay);
    return ticks + delay + 2;
  endfunction

  // software trigger is sticky; watchdog flag only clears, reserved bits read zero
  function automatic logic [15:0] exp_cst(input logic [15:0] w, input logic [15:0] old);
    return (w & 16'h3783) | (old & 16'h0400);
  endfunction

  // request held until ack is sampled, then one idle cycle
  task xfer(input logic w_en, input logic [7:0] a, input logic [15:0] v, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= a;
    wdat <= {16'h0000, v};
    sel <= s;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task wr(input logic [7:0] a, input logic [15:0] v);
    xfer(1'b1, a, v, 4'h3);
  endtask

  task rd(input logic [7:0] a);
    xfer(1'b0, a, 16'h0000, 4'h3);
  endtask

  task setup(input logic [15:0] con, input logic [15:0] sd, input logic [15:0] cst);
    wr(`TSC_ADR_CST, 16'h0000);
    wr(`TSC_ADR_CON, con);
    wr(`TSC_ADR_SDLIM, sd);
    wr(`TSC_ADR_CST, cst);
    repeat (3) @(posedge clk_i);
  endtask

  task clear;
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    @(posedge clk_i);
  endtask

  // c counts edges from the take edge to the one that sees the done pulse
  task step(input logic [7:0] b);
    int n;
    n = 0;
    c = 0;
    wd_seen = 1'b0;
    cvalid <= 1'b1;
    cbyte <= b;
    do begin
      @(posedge clk_i);
      n++;
    end while (cmd_ready_o !== 1'b1 && n < 100);
    cvalid <= 1'b0;
    do begin
      @(posedge clk_i);
      c++;
      if (wdo === 1'b1) wd_seen = 1'b1;
    end while (done !== 1'b1 && c < 2000);
    repeat (2) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h52db_9dd8));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    clr <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a <= 24; a += 4) begin
      rd(8'(a));
      chk(q, 32'h0000_0000, "reset value");
    end
    e = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom) & 16'h7eff;
      wr(`TSC_ADR_CST, w);
      e = exp_cst(w, e);
      rd(`TSC_ADR_CST);
      chk(q, e, "control status");
      w = 16'($urandom);
      wr(`TSC_ADR_CON, w);
      rd(`TSC_ADR_CON);
      chk(q, w & 16'hfff7, "clock config");
      wr(`TSC_ADR_T0LIM, w);
      rd(`TSC_ADR_T0LIM);
      chk(q, w, "timer0 limit");
    end
    wr(`TSC_ADR_T1LIM, 16'h0000);
    xfer(1'b1, `TSC_ADR_T1LIM, 16'hffff, 4'h1);
    rd(`TSC_ADR_T1LIM);
    chk(q, 16'h00ff, "byte lane");
    bte = 16'($urandom) | 16'h0011;
    wr(`TSC_ADR_BTE, bte);
    setup(16'h0000, 16'h0000, 16'h0080);
    chk(cmd_ready_o, 1'b0, "ready disabled");
    wr(`TSC_ADR_CST, 16'h8080);
    repeat (3) @(posedge clk_i);
    chk(cmd_ready_o, 1'b1, "ready running");
    wr(`TSC_ADR_BTE, ~bte);
    rd(`TSC_ADR_BTE);
    chk(q, bte, "locked enables");
    clear;
    step(8'h0f);
    chk(c, exp_time(0, 0), "broadcast time");
    chk(seen, bte, "broadcast lines");
    chk(bcnt, 1, "broadcast count");
    clear;
    step(8'h03);
    chk(bcnt, 0, "no broadcast");
    for (int i = 0; i < 3; i++) begin
      d = $urandom_range(5);
      setup({8'h00, 4'(pws[i]), 4'h0}, 16'(d), 16'h8080);
      clear;
      step(8'h80);
      chk(c, exp_time(0, d), "trigger step time");
      repeat (20) @(posedge clk_i);
      chk(plen, pws[i] + 1, "pulse width");
    end
    setup(16'h0000, 16'h0000, 16'h9080);
    step(8'h81);
    chk(trigger_output_o[1], 1'b1, "toggle high");
    step(8'h81);
    chk(trigger_output_o[1], 1'b0, "toggle low");
    // single step: start falls after one finished step
    setup(16'h0000, 16'h0000, 16'h8280);
    step(8'h03);
    rd(`TSC_ADR_CST);
    chk(q[7], 1'b0, "single step start");
    chk(cmd_ready_o, 1'b0, "single step ready");
    wr(`TSC_ADR_CST, 16'h0000);
    d = $urandom_range(9);
    wr(`TSC_ADR_T0LIM, 16'(d));
    setup(16'h0000, 16'h0000, 16'h8080);
    step(8'h08);
    chk(c, exp_time(d + 1, 0), "timer0 step time");
    wr(`TSC_ADR_CST, 16'h8180);
    rd(`TSC_ADR_T0LIM);
    chk(q, 16'(d), "live timer0");
    wr(`TSC_ADR_CST, 16'h8480);
    step(8'h0a);
    chk(c, exp_time(1, 0), "software trigger time");
    rd(`TSC_ADR_CST);
    chk(q[10], 1'b0, "software trigger consumed");
    // edge mode with and without the exit delay; source lag varies
    for (int m = 0; m < 2; m++) begin
      lvl <= 16'h0000;
      lag <= 4'($urandom_range(3));
      setup(16'h0000, 16'h0005, 16'h8080 | 16'(m));
      clear;
      fork
        step(8'h42);
        begin
          repeat (6) @(posedge clk_i);
          lvl <= 16'h0004;
        end
      join
      chk(m ? (c <= lag + 12) : (c >= lag + 13), 1'b1, "wait exit delay");
    end
    setup(16'h0000, 16'h0005, 16'h8083);
    step(8'h42);
    chk(c <= 6, 1'b1, "level detect");
    lvl <= 16'h0000;
    setup(16'h0001, 16'h0000, 16'h8080);
    clear;
    step(8'h45);
    chk(wd_seen, 1'b1, "watchdog pulse");
    chk(c >= 8 && c <= 14, 1'b1, "watchdog time");
    rd(`TSC_ADR_CST);
    chk(q[6], 1'b1, "timeout flag");
    wr(`TSC_ADR_CST, 16'h8080);
    rd(`TSC_ADR_CST);
    chk(q[6], 1'b0, "flag cleared");
    wr(`TSC_ADR_CST, 16'ha080);
    idle <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(cmd_ready_o, 1'b0, "idle stop");
    idle <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(cmd_ready_o, 1'b1, "idle resume");
    test_done;
  end
endmodule
